// ==== inc/status_pkg.sv ====
// Shared constants for the status register hierarchy.
// Assumes one system clock; all users refer to names as status_pkg::name.
package status_pkg;

   // ------------------------------------------------------------
   // Widths and counts
   // ------------------------------------------------------------
   localparam int PART_W   = 16;
   localparam int SRC_W    = PART_W - 1;
   localparam int NUM_SCPI = 3;
   localparam int STD_W    = 8;
   localparam int SBY_W    = 8;
   localparam int SYNC_N   = 3;

   // ------------------------------------------------------------
   // Register and part selectors
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_OPER    = 3'h0,
      SEL_QUES    = 3'h1,
      SEL_DEV     = 3'h2,
      SEL_STD     = 3'h3,
      SEL_SUMMARY = 3'h4
   } reg_sel_t;

   typedef enum logic [2:0] {
      PART_LIVE  = 3'h0,
      PART_RISE  = 3'h1,
      PART_FALL  = 3'h2,
      PART_EVENT = 3'h3,
      PART_MASK  = 3'h4
   } part_sel_t;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [SRC_W-1:0] RISE_RST     = 15'h7FFF;
   localparam logic [SRC_W-1:0] FALL_RST     = 15'h0000;
   localparam logic [SRC_W-1:0] MASK_RST     = 15'h0000;
   localparam logic [STD_W-1:0] STD_MASK_RST = 8'h00;
   localparam logic [SBY_W-1:0] RQM_RST      = 8'h00;

   // ------------------------------------------------------------
   // Service summary byte bit positions
   // ------------------------------------------------------------
   localparam int SBY_DEV_BIT  = 1;
   localparam int SBY_ERRQ_BIT = 2;
   localparam int SBY_QUES_BIT = 3;
   localparam int SBY_MSG_BIT  = 4;
   localparam int SBY_STD_BIT  = 5;
   localparam int SBY_MST_BIT  = 6;
   localparam int SBY_OPER_BIT = 7;
   localparam logic [SBY_W-1:0] MST_ONLY = 8'h01 << SBY_MST_BIT;

endpackage : status_pkg

// ==== core/status_part_set.sv ====
// One five-part status register: live, rise, fall, latched event, mask.
// Assumes live inputs are already synchronous to clk.
`timescale 1ns/100ps
module status_part_set #(
   parameter int WIDTH = status_pkg::PART_W
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic [WIDTH-2:0]   live,
   input  wire logic               wr_rise,
   input  wire logic               wr_fall,
   input  wire logic               wr_mask,
   input  wire logic               rd_event,
   input  wire logic [WIDTH-1:0]   wdata,
   output logic      [WIDTH-2:0]   cond_ff,
   output logic      [WIDTH-2:0]   rise_ff,
   output logic      [WIDTH-2:0]   fall_ff,
   output logic      [WIDTH-2:0]   event_ff,
   output logic      [WIDTH-2:0]   mask_ff,
   output logic      [WIDTH-2:0]   set_ev,
   output logic                    sum
);
   localparam int BW = WIDTH - 1;

   // ------------------------------------------------------------
   // Transition filters
   // ------------------------------------------------------------
   wire [BW-1:0] went_up   = live & ~cond_ff;
   wire [BW-1:0] went_down = ~live & cond_ff;
   wire [BW-1:0] nxt_event;

   assign set_ev    = (went_up & rise_ff) | (went_down & fall_ff);
   assign nxt_event = (rd_event ? '0 : event_ff) | set_ev;
   assign sum       = |(event_ff & mask_ff);

   // ------------------------------------------------------------
   // Storage, top bit never stored
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_ff  <= '0;
         rise_ff  <= BW'(status_pkg::RISE_RST);
         fall_ff  <= BW'(status_pkg::FALL_RST);
         mask_ff  <= BW'(status_pkg::MASK_RST);
         event_ff <= '0;
      end else begin
         cond_ff  <= live;
         event_ff <= nxt_event;
         if (wr_rise) rise_ff <= wdata[BW-1:0];
         if (wr_fall) fall_ff <= wdata[BW-1:0];
         if (wr_mask) mask_ff <= wdata[BW-1:0];
      end
   end

endmodule : status_part_set

// ==== core/status_register_hierarchy.sv ====
// Status reporting hierarchy: three five-part registers, a standard
// event latch and the service summary byte with service request.
// Assumes status sources arrive as asynchronous pins and a controller
// drives the command port synchronously to clk.
//
// Overview of operation
// - Each register has five 16-bit parts
// - One source uses one bit in all parts
// - Bit 15 always zero in every part
// - Live bits follow source or lower sum
// - Live part is read-only, unchanged by reads
// - Rising live bit sets event if rise filter
// - Falling live bit sets event if fall filter
// - Rise and fall filters freely readable, writable
// - Event bits stay set until read
// - Event part read-only, cleared by each read
// - Sum is OR of event AND mask
// - Event mask freely readable and writable
// - Sum bit drives a higher live bit
// - Summary byte and request mask at top
// - Summary fed by standard and register sums
// - Rising enabled summary bit raises request
// - Bit 6 is master summary, mask bit ignored
`timescale 1ns/100ps
module status_register_hierarchy #(
   parameter int PART_W = status_pkg::PART_W
) (
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   input  wire logic [status_pkg::SRC_W-1:0]   oper_src,
   input  wire logic [status_pkg::SRC_W-1:0]   ques_src,
   input  wire logic [status_pkg::SRC_W-1:0]   dev_src,
   input  wire logic [status_pkg::STD_W-1:0]   std_event_src,
   input  wire logic                           err_queue_busy,
   input  wire logic                           msg_avail,
   input  wire logic [2:0]                     cmd_sel,
   input  wire logic [2:0]                     cmd_part,
   input  wire logic                           cmd_wr,
   input  wire logic                           cmd_rd,
   input  wire logic [PART_W-1:0]              cmd_wdata,
   output logic      [PART_W-1:0]              rd_data_ff,
   output logic                                rd_valid_ff,
   output logic      [status_pkg::SBY_W-1:0]   summary_byte_ff,
   output logic                                srq_ff
);
   localparam int SRC_W = PART_W - 1;
   localparam int NSC   = status_pkg::NUM_SCPI;
   localparam int STD_W = status_pkg::STD_W;
   localparam int SBY_W = status_pkg::SBY_W;
   localparam int PIN_W = NSC * SRC_W + STD_W + 2;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   wire        rst_n = rst_sync_ff[1];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers, change taken when stages 2 and 3 agree
   // ------------------------------------------------------------
   wire [PIN_W-1:0] pin_in = {msg_avail, err_queue_busy, std_event_src,
                              dev_src, ques_src, oper_src};
   wire [PIN_W-1:0] pin_stable;

   for (genvar b = 0; b < PIN_W; b++) begin : g_sync
      logic [status_pkg::SYNC_N-1:0] stage_ff;
      logic                          keep_ff;
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            stage_ff <= '0;
            keep_ff  <= 1'b0;
         end else begin
            stage_ff <= {stage_ff[1:0], pin_in[b]};
            if (stage_ff[2] == stage_ff[1]) keep_ff <= stage_ff[2];
         end
      end
      assign pin_stable[b] = keep_ff;
   end

   wire [STD_W-1:0] std_stable = pin_stable[NSC*SRC_W +: STD_W];
   wire             errq_stable = pin_stable[NSC*SRC_W + STD_W];
   wire             msg_stable  = pin_stable[NSC*SRC_W + STD_W + 1];

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   wire part_live  = cmd_part == status_pkg::PART_LIVE;
   wire part_rise  = cmd_part == status_pkg::PART_RISE;
   wire part_fall  = cmd_part == status_pkg::PART_FALL;
   wire part_event = cmd_part == status_pkg::PART_EVENT;
   wire part_mask  = cmd_part == status_pkg::PART_MASK;
   wire sel_std    = cmd_sel == status_pkg::SEL_STD;
   wire sel_sum    = cmd_sel == status_pkg::SEL_SUMMARY;

   // ------------------------------------------------------------
   // Five-part registers, one per status group
   // ------------------------------------------------------------
   logic [SRC_W-1:0]  cond_q  [NSC];
   logic [SRC_W-1:0]  rise_q  [NSC];
   logic [SRC_W-1:0]  fall_q  [NSC];
   logic [SRC_W-1:0]  event_q [NSC];
   logic [SRC_W-1:0]  mask_q  [NSC];
   logic [SRC_W-1:0]  set_q   [NSC];
   logic [NSC-1:0]    sum_bits;
   logic [NSC-1:0]    rd_ev;
   logic [PART_W-1:0] scpi_rd [NSC];

   for (genvar i = 0; i < NSC; i++) begin : g_reg
      wire hit = cmd_sel == 3'(i);
      assign rd_ev[i] = cmd_rd && hit && part_event;
      status_part_set #(.WIDTH(PART_W)) u_part (
         .clk      (clk),
         .rst_n    (rst_n),
         .live     (pin_stable[i*SRC_W +: SRC_W]),
         .wr_rise  (cmd_wr && hit && part_rise),
         .wr_fall  (cmd_wr && hit && part_fall),
         .wr_mask  (cmd_wr && hit && part_mask),
         .rd_event (rd_ev[i]),
         .wdata    (cmd_wdata),
         .cond_ff  (cond_q[i]),
         .rise_ff  (rise_q[i]),
         .fall_ff  (fall_q[i]),
         .event_ff (event_q[i]),
         .mask_ff  (mask_q[i]),
         .set_ev   (set_q[i]),
         .sum      (sum_bits[i])
      );
      assign scpi_rd[i] = {1'b0,
                           part_live  ? cond_q[i]  :
                           part_rise  ? rise_q[i]  :
                           part_fall  ? fall_q[i]  :
                           part_event ? event_q[i] :
                           part_mask  ? mask_q[i]  : SRC_W'(0)};
   end

   // ------------------------------------------------------------
   // Standard event latch and its mask
   // ------------------------------------------------------------
   logic [STD_W-1:0] std_prev_ff;
   logic [STD_W-1:0] std_latch_ff;
   logic [STD_W-1:0] std_mask_ff;
   wire              rd_std = cmd_rd && sel_std && part_event;
   wire [STD_W-1:0]  std_rise = std_stable & ~std_prev_ff;
   wire [STD_W-1:0]  nxt_std_latch = (rd_std ? '0 : std_latch_ff) | std_rise;
   wire              std_sum = |(std_latch_ff & std_mask_ff);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         std_prev_ff  <= '0;
         std_latch_ff <= '0;
         std_mask_ff  <= status_pkg::STD_MASK_RST;
      end else begin
         std_prev_ff  <= std_stable;
         std_latch_ff <= nxt_std_latch;
         if (cmd_wr && sel_std && part_mask)
            std_mask_ff <= cmd_wdata[STD_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Service summary byte and service request
   // ------------------------------------------------------------
   logic [SBY_W-1:0] rqm_ff;
   logic [SBY_W-1:0] req_prev_ff;
   logic [SBY_W-1:0] sby_low;

   always_comb begin
      sby_low = '0;
      sby_low[status_pkg::SBY_OPER_BIT] = sum_bits[0];
      sby_low[status_pkg::SBY_QUES_BIT] = sum_bits[1];
      sby_low[status_pkg::SBY_DEV_BIT]  = sum_bits[2];
      sby_low[status_pkg::SBY_STD_BIT]  = std_sum;
      sby_low[status_pkg::SBY_ERRQ_BIT] = errq_stable;
      sby_low[status_pkg::SBY_MSG_BIT]  = msg_stable;
   end

   wire [SBY_W-1:0] req_bits = sby_low & rqm_ff & ~status_pkg::MST_ONLY;
   wire             mst      = |req_bits;
   wire [SBY_W-1:0] sby_full = sby_low | (mst ? status_pkg::MST_ONLY : '0);
   wire             nxt_srq  = |(req_bits & ~req_prev_ff);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rqm_ff          <= status_pkg::RQM_RST;
         req_prev_ff     <= '0;
         summary_byte_ff <= '0;
         srq_ff          <= 1'b0;
      end else begin
         req_prev_ff     <= req_bits;
         summary_byte_ff <= sby_full;
         srq_ff          <= nxt_srq;
         if (cmd_wr && sel_sum && part_mask)
            rqm_ff <= cmd_wdata[SBY_W-1:0] & ~status_pkg::MST_ONLY;
      end
   end

   // ------------------------------------------------------------
   // Read path, one cycle latency
   // ------------------------------------------------------------
   wire [PART_W-1:0] std_rd = part_live  ? PART_W'(std_stable)   :
                              part_event ? PART_W'(std_latch_ff) :
                              part_mask  ? PART_W'(std_mask_ff)  : '0;
   wire [PART_W-1:0] sum_rd = part_live  ? PART_W'(sby_full) :
                              part_mask  ? PART_W'(rqm_ff)   : '0;
   wire [PART_W-1:0] rd_mux = cmd_sel == status_pkg::SEL_OPER ? scpi_rd[0] :
                              cmd_sel == status_pkg::SEL_QUES ? scpi_rd[1] :
                              cmd_sel == status_pkg::SEL_DEV  ? scpi_rd[2] :
                              sel_std ? std_rd :
                              sel_sum ? sum_rd : '0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_ff  <= '0;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= cmd_rd;
         if (cmd_rd) rd_data_ff <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_rd_ev0;
      cmd_rd && cmd_sel == status_pkg::SEL_OPER && part_event;
   endsequence
   sequence s_wr_mask1;
      cmd_wr && cmd_sel == status_pkg::SEL_QUES && part_mask;
   endsequence
   sequence s_rd_mask1;
      cmd_rd && !cmd_wr && cmd_sel == status_pkg::SEL_QUES && part_mask;
   endsequence

   a_top_bit_zero: assert property (
      rd_valid_ff |-> !rd_data_ff[PART_W-1])
      else $error("top bit of read data not zero");
   a_live_follow: assert property (
      cond_q[1] == $past(pin_stable[SRC_W +: SRC_W]))
      else $error("live part does not follow source");
   a_live_ro: assert property (
      (cmd_wr && part_live && $stable(pin_stable)) |=> $stable(cond_q[0]))
      else $error("live part changed by write");
   a_rise_set: assert property (
      ($rose(pin_stable[2]) && rise_q[0][2]) |=> event_q[0][2])
      else $error("rise did not set event");
   a_fall_set: assert property (
      ($fell(pin_stable[SRC_W+4]) && fall_q[1][4]) |=> event_q[1][4])
      else $error("fall did not set event");
   a_event_sticky: assert property (
      (!rd_ev[0] && event_q[0][0]) |=> event_q[0][0])
      else $error("event bit lost without read");
   a_filter_write: assert property (
      (cmd_wr && cmd_sel == status_pkg::SEL_DEV && part_fall)
      |=> fall_q[2] == $past(cmd_wdata[SRC_W-1:0]))
      else $error("fall filter write lost");
   a_event_clear: assert property (
      s_rd_ev0 ##0 (set_q[0] == '0) |=> event_q[0] == '0)
      else $error("event part not cleared by read");
   a_event_race: assert property (
      s_rd_ev0 ##0 (set_q[0] != '0) |=> event_q[0] == $past(set_q[0]))
      else $error("event arriving during read lost");
   a_mask_readback: assert property (
      s_wr_mask1 ##1 s_rd_mask1
      |=> rd_data_ff == {1'b0, $past(cmd_wdata[SRC_W-1:0], 2)})
      else $error("mask read back wrong");
   a_sum_feed: assert property (
      summary_byte_ff[status_pkg::SBY_QUES_BIT]
      == $past(|(event_q[1] & mask_q[1])))
      else $error("sum bit not fed upward");
   a_master_sum: assert property (
      summary_byte_ff[status_pkg::SBY_MST_BIT] == $past(|req_bits))
      else $error("master summary wrong");
   a_srq_pulse: assert property (
      srq_ff |-> $past(|(req_bits & ~req_prev_ff)))
      else $error("request without enabled rising bit");
   a_srq_rise: assert property (
      (|(req_bits & ~req_prev_ff)) |=> srq_ff)
      else $error("enabled rising bit raised no request");
   a_req_mask_b6: assert property (
      !rqm_ff[status_pkg::SBY_MST_BIT])
      else $error("request mask master bit stored");
   a_std_latch: assert property (
      (std_stable[0] && !std_prev_ff[0]) |=> std_latch_ff[0])
      else $error("standard event rise not latched");
   a_filter_hold: assert property (
      !(cmd_wr && cmd_sel == status_pkg::SEL_OPER && part_rise)
      |=> $stable(rise_q[0]))
      else $error("rise filter changed without write");
   a_event_filtered: assert property (
      (!event_q[1][4] && !set_q[1][4]) |=> !event_q[1][4])
      else $error("event set without filtered transition");

endmodule : status_register_hierarchy

// ==== test/host_ctrl_model.sv ====
// Remote controller model: issues status commands on the command port.
// Assumes the bench calls its tasks only after reset has been released.
`timescale 1ns/100ps
module host_ctrl_model (
   input  wire logic        clk,
   output logic      [2:0]  cmd_sel,
   output logic      [2:0]  cmd_part,
   output logic             cmd_wr,
   output logic             cmd_rd,
   output logic      [15:0] cmd_wdata,
   input  wire logic [15:0] rd_data_ff,
   input  wire logic        rd_valid_ff
);
   // ----------------------------------------
   // Idle: unmapped selector, strobes low
   // ----------------------------------------
   initial begin
      cmd_sel = 3'h7;
      cmd_part = 3'h7;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_wdata = 16'h0000;
   end

   task automatic wr(input logic [2:0] s, input logic [2:0] p,
                     input logic [15:0] d);
      @(negedge clk);
      cmd_sel = s;
      cmd_part = p;
      cmd_wdata = d;
      cmd_wr = 1'b1;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [2:0] s, input logic [2:0] p,
                     output logic [15:0] d, output logic v);
      @(negedge clk);
      cmd_sel = s;
      cmd_part = p;
      cmd_rd = 1'b1;
      @(negedge clk);
      cmd_rd = 1'b0;
      v = rd_valid_ff;
      d = rd_data_ff;
   endtask : rd

   task automatic wr_rd(input logic [2:0] s, input logic [2:0] p,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic v);
      @(negedge clk);
      cmd_sel = s;
      cmd_part = p;
      cmd_wdata = d;
      cmd_wr = 1'b1;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_wdata = ~d;
      cmd_rd = 1'b1;
      @(negedge clk);
      cmd_rd = 1'b0;
      v = rd_valid_ff;
      q = rd_data_ff;
   endtask : wr_rd
endmodule : host_ctrl_model

// ==== test/status_register_hierarchy_tb_top.sv ====
// Self-checking bench for the status register hierarchy.
// Assumes the controller model drives the command port.
`timescale 1ns/100ps
module status_register_hierarchy_tb_top;
   logic        clk;
   logic        rst_b;
   logic [14:0] oper_src;
   logic [14:0] ques_src;
   logic [14:0] dev_src;
   logic [7:0]  std_event_src;
   logic        err_queue_busy;
   logic        msg_avail;
   logic [2:0]  cmd_sel;
   logic [2:0]  cmd_part;
   logic        cmd_wr;
   logic        cmd_rd;
   logic [15:0] cmd_wdata;
   logic [15:0] rd_data_ff;
   logic        rd_valid_ff;
   logic [7:0]  summary_byte_ff;
   logic        srq_ff;
   int          err_total = 0;
   int          compares = 0;
   int          srq_cnt = 0;
   integer      seed = 32'h0724;
   logic [14:0] prev [0:2];

   status_register_hierarchy status_register_hierarchy_i (.*);
   host_ctrl_model host_ctrl_model_i (.*);

   always #5 clk = ~clk;

   always @(posedge clk) begin
      if (srq_ff === 1'b1) srq_cnt <= srq_cnt + 1;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input int s, input int p, input logic [15:0] d);
      host_ctrl_model_i.wr(3'(s), 3'(p), d);
   endtask : wr

   task automatic rd_chk(input string n, input int s, input int p,
                         input logic [15:0] e);
      logic [15:0] d;
      logic        v;
      host_ctrl_model_i.rd(3'(s), 3'(p), d, v);
      chk(n, 16'h0001, {15'h0000, v});
      chk(n, e, d);
   endtask : rd_chk

   task automatic wr_rd_chk(input string n, input int s, input int p,
                            input logic [15:0] w);
      logic [15:0] d;
      logic        v;
      host_ctrl_model_i.wr_rd(3'(s), 3'(p), w, d, v);
      chk(n, 16'h0001, {15'h0000, v});
      chk(n, {1'b0, w[14:0]}, d);
   endtask : wr_rd_chk

   task automatic set_src(input int k, input logic [14:0] v);
      @(negedge clk);
      if (k == 0) oper_src = v;
      else if (k == 1) ques_src = v;
      else dev_src = v;
      repeat (10) @(negedge clk);
   endtask : set_src

   function automatic int sby_bit(input int k);
      if (k == 0) return status_pkg::SBY_OPER_BIT;
      if (k == 1) return status_pkg::SBY_QUES_BIT;
      return status_pkg::SBY_DEV_BIT;
   endfunction : sby_bit

   task automatic test_done;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [15:0] r;
      logic [15:0] f;
      logic [15:0] m;
      logic [15:0] v;
      logic [14:0] ev;
      logic        sum;
      int          k;
      int          n0;
      clk = 1'b0;
      rst_b = 1'b0;
      {oper_src, ques_src, dev_src} = '0;
      std_event_src = 8'h00;
      err_queue_busy = 1'b0;
      msg_avail = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      for (k = 0; k < 3; k++) begin
         rd_chk("rise rst", k, 1, 16'h7FFF);
         rd_chk("fall rst", k, 2, 16'h0000);
         rd_chk("mask rst", k, 4, 16'h0000);
         rd_chk("event rst", k, 3, 16'h0000);
         prev[k] = '0;
      end
      rd_chk("unmapped", 5, 0, 16'h0000);
      wr_rd_chk("mask b2b", 1, 4, 16'hD5A3);
      wr(4, 4, 16'hFFFF);
      rd_chk("req mask", 4, 4, 16'h00BF);
      for (int i = 0; i < 18; i++) begin
         k = i % 3;
         r = 16'($random(seed));
         f = 16'($random(seed));
         m = 16'($random(seed));
         v = 16'($random(seed));
         if (i < 3) r = 16'hFFFF;
         wr(k, 1, r);
         wr(k, 2, f);
         wr(k, 4, m);
         rd_chk("rise", k, 1, {1'b0, r[14:0]});
         rd_chk("fall", k, 2, {1'b0, f[14:0]});
         rd_chk("mask", k, 4, {1'b0, m[14:0]});
         n0 = srq_cnt;
         set_src(k, v[14:0]);
         ev = (~prev[k] & v[14:0] & r[14:0]) | (prev[k] & ~v[14:0] & f[14:0]);
         sum = |(ev & m[14:0]);
         chk("sum", {15'h0, sum},
             {15'h0, summary_byte_ff[sby_bit(k)]});
         chk("master", {15'h0, sum}, {15'h0, summary_byte_ff[6]});
         chk("srq", {15'h0, sum}, 16'(srq_cnt - n0));
         wr(k, 0, 16'hFFFF);
         wr(k, 3, 16'hFFFF);
         rd_chk("live", k, 0, {1'b0, v[14:0]});
         rd_chk("event", k, 3, {1'b0, ev});
         rd_chk("event clr", k, 3, 16'h0000);
         prev[k] = v[14:0];
      end
      wr(0, 1, 16'h7FFF);
      wr(0, 2, 16'h7FFF);
      @(negedge clk);
      oper_src = ~prev[0];
      repeat (3) @(negedge clk);
      rd_chk("race rd", 0, 3, 16'h0000);
      rd_chk("race keep", 0, 3, 16'h7FFF);
      prev[0] = oper_src;
      repeat (3) @(negedge clk);
      wr(3, 4, 16'h00FF);
      @(negedge clk);
      std_event_src = 8'h05;
      repeat (10) @(negedge clk);
      chk("std sum", 16'h0060, {8'h00, summary_byte_ff});
      rd_chk("std event", 3, 3, 16'h0005);
      err_queue_busy = 1'b1;
      msg_avail = 1'b1;
      repeat (10) @(negedge clk);
      chk("err mav", 16'h0054, {8'h00, summary_byte_ff});
      wr(4, 4, 16'h0000);
      repeat (3) @(negedge clk);
      chk("no master", 16'h0014, {8'h00, summary_byte_ff});
      rd_chk("summary", 4, 0, 16'h0014);
      test_done();
   end

   initial begin
      #200000;
      err_total++;
      test_done();
   end
endmodule : status_register_hierarchy_tb_top
